// ===== spsd_consts.vh
// Constants for the serial port strap decoder
`ifndef SPSD_CONSTS_VH
`define SPSD_CONSTS_VH
// Init sequence step counts
`define SPSD_SETTLE_CYCLES 8'h10
`define SPSD_SYNC_STAGES 2
// Async bit rates in bps
`define SPSD_RATE_1200 18'h004B0
`define SPSD_RATE_2400 18'h00960
`define SPSD_RATE_4800 18'h012C0
`define SPSD_RATE_9600 18'h02580
`define SPSD_RATE_19200 18'h04B00
`define SPSD_RATE_38400 18'h09600
`define SPSD_RATE_76800 18'h12C00
`define SPSD_RATE_153600 18'h25800
`define SPSD_RATE_115200 18'h1C200
// SPI role codes
`define SPSD_SPI_OFF 2'h0
`define SPSD_SPI_MASTER 2'h1
`define SPSD_SPI_SLAVE 2'h2
// Main port mode codes
`define SPSD_PORT_OFF 2'h0
`define SPSD_PORT_ASYNC 2'h1
`define SPSD_PORT_SYNC 2'h2
// Flow control codes
`define SPSD_FLOW_XON 1'h0
`define SPSD_FLOW_RTSCTS 1'h1
`endif

// ===== spsd_strap_decoder.v
// Strap decoder choosing serial port rate, flow control and SPI role
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// (R1) Strap3 low: eight async rates, XON/XOFF
// (R2) Strap3 high: straps reinterpreted as SPI config
// (R3) All straps sampled during initialization
// (R4) SPI master, async port, software rate
// (R5) SPI master, sync port clocked by pin
// (R6) SPI slave, strap0 clock in, port off
// (R7) Strap0 low others high: 115200 RTS/CTS
// (R8) All high: 115200 XON/XOFF, SPI off
// (R9) RTS/CTS selected enables handshake pins
// (R10) Board keeps CTS pin ungrounded for handshake
// (R11) Host uses main port in SPI master
// (R12) SPI master serves only font memory
// (R13) Software rate applies only after reboot
// (R14) Polarity and phase sampled after straps
// (R15) Decoded setup held until next reset
`include "spsd_consts.vh"
module spsd_strap_decoder #(
   parameter SETTLE = `SPSD_SETTLE_CYCLES // Cycles before straps are sampled
) (
   input wire clk, // 100 MHz clock
   input wire rst, // Async reset, active high
   input wire config_strap_0, // Strap 0 pin
   input wire config_strap_1, // Strap 1 pin
   input wire config_strap_2, // Strap 2 pin
   input wire config_strap_3, // Strap 3 pin
   input wire clear_to_send_polarity_pin, // CTS or clock polarity pin
   input wire sync_clock_phase_pin, // Sync clock or clock phase pin
   input wire [17:0] saved_rate, // Software rate saved in setup
   input wire saved_rate_valid, // Saved rate present
   output reg config_done, // Configuration latched
   output reg [17:0] async_rate, // Main port bit rate in bps
   output reg [1:0] port_mode, // Main port mode code
   output reg flow_rtscts, // High for RTS/CTS flow control
   output reg handshake_en, // RTS out and CTS in active
   output reg [1:0] spi_role, // SPI role code
   output reg spi_font_only, // SPI serves font memory only
   output reg spi_clock_out, // Strap 0 pin becomes SPI clock out
   output reg [1:0] spi_mode // SPI clock mode 0 to 3
);
   // Init sequence states
   localparam ST_SETTLE = 2'h0;
   localparam ST_STRAPS = 2'h1;
   localparam ST_CLKMODE = 2'h2;
   localparam ST_DONE = 2'h3;
   // Sequencer and synchroniser flops
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [7:0] cnt_reg;
   reg [7:0] cnt_next;
   reg [5:0] s1_reg;
   reg [5:0] s2_reg;
   // Next values of the latched setup
   reg config_done_next;
   reg [17:0] async_rate_next;
   reg [1:0] port_mode_next;
   reg flow_rtscts_next;
   reg handshake_en_next;
   reg [1:0] spi_role_next;
   reg spi_font_only_next;
   reg spi_clock_out_next;
   reg [1:0] spi_mode_next;
   // Raw pins and their synchronised copies
   wire [5:0] pins_in;
   wire [3:0] strap_sync;
   wire cpol_sync;
   wire cpha_sync;
   wire latch_straps;
   wire latch_clkmode;
   assign pins_in = {sync_clock_phase_pin, clear_to_send_polarity_pin, config_strap_3,
      config_strap_2, config_strap_1, config_strap_0};
   assign strap_sync = s2_reg[3:0];
   assign cpol_sync = s2_reg[4];
   assign cpha_sync = s2_reg[5];
   // One-cycle strobes for the two sampling steps
   assign latch_straps = (state_reg == ST_STRAPS);
   assign latch_clkmode = (state_reg == ST_CLKMODE);
   // Low-strap rate table
   function [17:0] spsd_rate;
      input [2:0] s;
      begin
         case (s)
            3'h0: spsd_rate = `SPSD_RATE_1200;
            3'h4: spsd_rate = `SPSD_RATE_2400;
            3'h5: spsd_rate = `SPSD_RATE_4800;
            3'h7: spsd_rate = `SPSD_RATE_9600;
            3'h6: spsd_rate = `SPSD_RATE_19200;
            3'h3: spsd_rate = `SPSD_RATE_38400;
            3'h2: spsd_rate = `SPSD_RATE_76800;
            default: spsd_rate = `SPSD_RATE_153600;
         endcase
      end
   endfunction
   // Pin synchronisers; only the second stage feeds logic
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_reg <= 6'h00;
         s2_reg <= 6'h00;
      end else begin
         s1_reg <= pins_in;
         s2_reg <= s1_reg;
      end
   end
   // Sequencer: settle count, straps, clock mode, then hold
   always @* begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         ST_SETTLE: begin
            if (cnt_reg == SETTLE) begin
               state_next = ST_STRAPS;
            end else begin
               cnt_next = cnt_reg + 8'h01;
            end
         end
         ST_STRAPS: begin
            state_next = ST_CLKMODE; // see (R3)
         end
         ST_CLKMODE: begin
            state_next = ST_DONE; // Clock pins right after straps, see (R14)
         end
         ST_DONE: begin
            state_next = ST_DONE; // Held until reset, see (R15)
         end
         default: begin
            state_next = ST_SETTLE;
         end
      endcase
   end
   // Sequencer registers
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_SETTLE;
         cnt_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end
   // Setup decode, active only in the two sampling steps
   always @* begin
      config_done_next = config_done;
      async_rate_next = async_rate;
      port_mode_next = port_mode;
      flow_rtscts_next = flow_rtscts;
      handshake_en_next = handshake_en;
      spi_role_next = spi_role;
      spi_font_only_next = spi_font_only;
      spi_clock_out_next = spi_clock_out;
      spi_mode_next = spi_mode;
      if (latch_straps) begin
         if (!strap_sync[3]) begin
            async_rate_next = spsd_rate(strap_sync[2:0]); // see (R1)
            port_mode_next = `SPSD_PORT_ASYNC;
            flow_rtscts_next = `SPSD_FLOW_XON;
         end else begin
            // Straps now mean SPI role and handshake, see (R2)
            case (strap_sync[2:1])
               2'h0: begin
                  spi_role_next = `SPSD_SPI_MASTER; // see (R4)
                  spi_clock_out_next = 1'h1;
                  spi_font_only_next = 1'h1; // see (R12)
                  port_mode_next = `SPSD_PORT_ASYNC;
                  // Saved rate only read at boot, see (R13)
                  if (saved_rate_valid) begin
                     async_rate_next = saved_rate;
                  end else begin
                     async_rate_next = `SPSD_RATE_9600;
                  end
               end
               2'h2: begin
                  spi_role_next = `SPSD_SPI_MASTER; // see (R5)
                  spi_clock_out_next = 1'h1;
                  spi_font_only_next = 1'h1; // see (R12)
                  port_mode_next = `SPSD_PORT_SYNC;
               end
               2'h1: begin
                  spi_role_next = `SPSD_SPI_SLAVE; // see (R6)
                  port_mode_next = `SPSD_PORT_OFF;
               end
               default: begin
                  async_rate_next = `SPSD_RATE_115200; // see (R7) (R8)
                  port_mode_next = `SPSD_PORT_ASYNC;
                  if (strap_sync[0]) begin
                     flow_rtscts_next = `SPSD_FLOW_XON; // see (R8)
                     handshake_en_next = 1'h0;
                  end else begin
                     flow_rtscts_next = `SPSD_FLOW_RTSCTS; // see (R7)
                     handshake_en_next = 1'h1; // see (R9)
                  end
               end
            endcase
         end
      end
      if (latch_clkmode) begin
         spi_mode_next = {cpol_sync, cpha_sync}; // see (R14)
         config_done_next = 1'h1;
      end
   end
   // Setup registers; every top output comes from here
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         config_done <= 1'h0;
         async_rate <= `SPSD_RATE_9600;
         port_mode <= `SPSD_PORT_ASYNC;
         flow_rtscts <= `SPSD_FLOW_XON;
         handshake_en <= 1'h0;
         spi_role <= `SPSD_SPI_OFF;
         spi_font_only <= 1'h0;
         spi_clock_out <= 1'h0;
         spi_mode <= 2'h0;
      end else begin
         config_done <= config_done_next;
         async_rate <= async_rate_next;
         port_mode <= port_mode_next;
         flow_rtscts <= flow_rtscts_next;
         handshake_en <= handshake_en_next;
         spi_role <= spi_role_next;
         spi_font_only <= spi_font_only_next;
         spi_clock_out <= spi_clock_out_next;
         spi_mode <= spi_mode_next;
      end
   end
endmodule // spsd_strap_decoder
`default_nettype wire

// ===== spsd_board.sv
// Board model: strap resistors and clock mode pins
`timescale 1ns/10ps
`default_nettype none
module spsd_board (
   input wire logic [5:0] want, // CPOL, CPHA, straps 3..0
   output wire logic [5:0] pins // Pin levels
);
   assign pins = {want[5] | (want[3:0] == 4'hE), want[4:0]}; // Pull-up on CTS
endmodule // spsd_board
`default_nettype wire

// ===== spsd_checker.sv
// Strap decoder checker
`timescale 1ns/10ps
`default_nettype none
module spsd_checker (
   input wire logic clk, // Clock
   input wire logic rst, // Reset
   input wire logic config_done, // Latched
   input wire logic [17:0] async_rate, // Rate
   input wire logic [1:0] port_mode, // Port
   input wire logic flow_rtscts, // Flow
   input wire logic handshake_en, // Pins on
   input wire logic [1:0] spi_role, // Role
   input wire logic spi_font_only, // Font only
   input wire logic spi_clock_out, // Clock out
   input wire logic [1:0] spi_mode // Clock mode
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   a_done_held: assert property (config_done |=> config_done)
      else $error("done");
   a_role_held: assert property (config_done |=> $stable(spi_role))
      else $error("held");
   a_setup_held: assert property (config_done |=> $stable({async_rate, spi_mode}))
      else $error("setup");
   a_hs_flow: assert property (handshake_en == flow_rtscts)
      else $error("flow");
   a_sync_role: assert property (port_mode[1] |-> spi_role == 2'h1)
      else $error("sync");
   a_slave_off: assert property (spi_role[1] |-> port_mode == 2'h0)
      else $error("slave");
   a_master_on: assert property (spi_role[0] |-> port_mode != 2'h0)
      else $error("role");
   a_off_async: assert property (!spi_role |-> port_mode == 2'h1)
      else $error("off");
   a_rts_nospi: assert property (flow_rtscts |-> !spi_role)
      else $error("rts");
   a_font_master: assert property (spi_font_only == (spi_role == 2'h1))
      else $error("font");
   a_clk_master: assert property (spi_clock_out == (spi_role == 2'h1))
      else $error("clock");
endmodule // spsd_checker
bind spsd_strap_decoder spsd_checker chk (.clk(clk), .rst(rst), .config_done(config_done),
   .async_rate(async_rate), .port_mode(port_mode), .flow_rtscts(flow_rtscts),
   .handshake_en(handshake_en), .spi_role(spi_role), .spi_font_only(spi_font_only),
   .spi_clock_out(spi_clock_out), .spi_mode(spi_mode));
`default_nettype wire

// ===== serial_port_strap_decoder_tb.sv
// Bench for the strap decoder
`timescale 1ns/10ps
`default_nettype none
module serial_port_strap_decoder_tb;
   localparam [87:0] T = {64'h20B0474708082727, 24'h711BB8}; // Mode bits, rate shifts
   logic clk = 1'h0, rst = 1'h1;
   logic [24:0] cfg = 25'h0; // Saved rate, pin levels
   wire [5:0] p;
   wire [28:0] o;
   integer n_mismatch = 0, checked = 0, i = $urandom(97);
   always #5 clk = ~clk; // 100 MHz
   spsd_board brd (.want(cfg[5:0]), .pins(p));
   spsd_strap_decoder #(.SETTLE(8'h04)) uut (.clk(clk), .rst(rst), .config_strap_0(p[0]),
      .config_strap_1(p[1]), .config_strap_2(p[2]), .config_strap_3(p[3]),
      .clear_to_send_polarity_pin(p[5]), .sync_clock_phase_pin(p[4]), .saved_rate(cfg[23:6]),
      .saved_rate_valid(cfg[24]), .config_done(o[28]), .async_rate(o[27:10]),
      .flow_rtscts(o[9]), .port_mode(o[8:7]), .handshake_en(o[6]), .spi_role(o[5:4]),
      .spi_font_only(o[3]), .spi_clock_out(o[2]), .spi_mode(o[1:0]));
   function automatic [28:0] ex(input [5:0] v, input [18:0] r);
      ex = {1'h1, 18'h004B0 << T[v[2:0] * 3 +: 3], 8'h20, v[5] | v[3:0] == 4'hE, v[4]};
      if (v[3])
         ex[27:2] = {v[2:1] ? 18'h1C200 : r[18] ? r[17:0] : 18'h02580, T[24 + v[2:0] * 8 +: 8]};
   endfunction
   task compare(input [28:0] x);
      checked = checked + 1;
      if (((o ^ x) & {1'h1, {18{x[8:7] == 2'h1}}, 10'h3FF}) !== 29'h0) begin
         n_mismatch = n_mismatch + 1;
         $display("unexpected setup exp %h got %h", x, o);
      end
   endtask
   task run(input [5:0] v);
      {rst, cfg} = {1'h1, 19'($urandom), v};
      repeat (5) @(negedge clk);
      rst = 1'b0;
      repeat (12) @(negedge clk);
      compare(ex(v, cfg[24:6]));
      cfg = ~cfg;
      repeat (8) @(negedge clk);
      compare(ex(v, ~cfg[24:6]));
   endtask
   initial begin
      for (i = 0; i < 24; i = i + 1)
         run(i < 16 ? {i[3:2] ^ i[1:0], i[3:0]} : 6'($urandom));
      final_report(0);
   end
   initial #20000 final_report(1); // Watchdog
   task final_report(input integer hung);
      n_mismatch = n_mismatch + hung;
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
endmodule // serial_port_strap_decoder_tb
`default_nettype wire
